// ### hw/i2cms_pkg.sv
// Purpose: constants for the two-wire master byte sequencer
// Assumes: 8-bit rate reload value, byte-wide holding buffer
// Notes: control and status bits travel as plain ports, no register bus
package i2cms_pkg;
   // ======================================================================
   // widths and counts
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RATE_W = 8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ACK_BIT_NUM = 4'h9;
   // ======================================================================
   // reset values
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] CNT_RST = 4'h0;
   // ======================================================================
   // master engine phases
   typedef enum logic [3:0] {
      I2CMS_IDLE,
      I2CMS_RS_LOW,
      I2CMS_RS_SDAHI,
      I2CMS_RS_WAITHI,
      I2CMS_RS_BOTHHI,
      I2CMS_RS_SDALO,
      I2CMS_TX_LOW,
      I2CMS_TX_HIGH,
      I2CMS_RX_LOW,
      I2CMS_RX_HIGH,
      I2CMS_ACK_LOW,
      I2CMS_ACK_HIGH
   } i2cms_state_e;
endpackage

// ### hw/i2cms_sequencer.sv
// Purpose: master byte sequencer: restart, transmit, receive, acknowledge
// Assumes: SDA and SCL are open-drain, sampled through two flip-flops
// Notes: requests are one-cycle pulses; flags clear on one-cycle pulses
//
// Summary of operation
// - restart from idle pulls SCL low, loads counter once SCL reads low.
// - restart releases SDA one period, then SCL if SDA high, reload on SCL high.
// - both high one period, SDA low one period, SCL low, request clears.
// - start-seen sets on start pattern; irq flag only after counter timeout.
// - restart request ignored while any other bus event runs.
// - restart collision: SDA low as SCL rises, or SCL falls early.
// - buffer write sets full flag, starts counter and shifting.
// - bit driven after SCL fall; SCL low one period, high one period.
// - after eighth fall, clear full flag and release SDA for acknowledge.
// - ninth bit sampled into acknowledge status, 0 acknowledge, 1 none.
// - after ninth clock set irq flag, hold SCL low, counter stops.
// - address byte is seven bits then direction bit, then acknowledge.
// - buffer write during transmit sets write collision, buffer unchanged.
// - receive request honoured only while idle, else disregarded.
// - receive toggles SCL per rollover, shifts SDA, stores byte, flags.
// - in receive, reading the buffer clears the full flag.
// - overrun set when a byte completes while full flag still set.
// - buffer write during receive sets write collision, write ignored.
// - acknowledge send pulls SCL low, drives value, counts, releases SCL.
// - SCL high, count one period, SCL low, request clears, idle.
// - every counter load takes the 8-bit reload value.
// - counter pauses after SCL release until SCL reads high.
`timescale 1ns/1ps
`default_nettype none
module i2cms_sequencer (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [i2cms_pkg::RATE_W-1:0] RATE_RELOAD_VALUE,
   input wire logic [i2cms_pkg::DATA_W-1:0] BUF_WDATA,
   input wire logic BUF_WR,
   input wire logic BUF_RD,
   input wire logic RESTART_REQUEST,
   input wire logic RECEIVE_REQUEST,
   input wire logic ACK_SEND_REQUEST,
   input wire logic ACK_VALUE_BIT,
   input wire logic IRQ_CLR,
   input wire logic WRITE_COLLISION_FLAG_CLR,
   input wire logic OVR_CLR,
   input wire logic BCOL_CLR,
   input wire logic SDA_IN,
   input wire logic SCL_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic SCL_OUT,
   output logic SCL_OE,
   output logic [i2cms_pkg::DATA_W-1:0] HOLDING_BUFFER,
   output logic HOLDING_FULL_FLAG,
   output logic WRITE_COLLISION_FLAG,
   output logic RECEIVE_OVERRUN_FLAG,
   output logic ACK_RECEIVED_STATUS,
   output logic PORT_IRQ_FLAG,
   output logic START_SEEN,
   output logic BUS_COLLISION,
   output logic RESTART_BUSY,
   output logic RECEIVE_BUSY,
   output logic ACK_SEND_BUSY
);
   import i2cms_pkg::*;

   // ======================================================================
   // pin synchronisers
   logic [1:0] sda_sync_ff;
   logic [1:0] scl_sync_ff;
   logic sda_prev_ff;
   logic scl_prev_ff;
   logic sda_s;
   logic scl_s;

   // two stages before any logic looks at the lines
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sda_sync_ff <= 2'h3;
         scl_sync_ff <= 2'h3;
         sda_prev_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
      end else begin
         sda_sync_ff <= {sda_sync_ff[0], SDA_IN};
         scl_sync_ff <= {scl_sync_ff[0], SCL_IN};
         sda_prev_ff <= sda_sync_ff[1];
         scl_prev_ff <= scl_sync_ff[1];
      end
   end
   assign sda_s = sda_sync_ff[1];
   assign scl_s = scl_sync_ff[1];

   // ======================================================================
   // state and datapath registers
   i2cms_state_e state_ff;
   logic [RATE_W-1:0] rate_cnt_ff;
   logic cnt_run_ff;
   logic [3:0] bit_cnt_ff;
   logic [DATA_W-1:0] shift_ff;
   logic [DATA_W-1:0] hold_ff;
   logic sda_drv_low_ff;
   logic scl_drv_low_ff;
   logic full_ff;
   logic write_collision_flag_ff;
   logic ovr_ff;
   logic ack_received_status_ff;
   logic irq_ff;
   logic start_ff;
   logic bcol_ff;
   logic rs_req_ff;
   logic rx_req_ff;
   logic ack_req_ff;
   logic irq_set;
   logic bcol_set;
   logic ovr_set;
   logic timeout;
   logic idle;

   // engine is idle only when no sequence or shift is active
   assign idle = (state_ff == I2CMS_IDLE);
   // timeout when the running counter reaches zero
   assign timeout = cnt_run_ff && (rate_cnt_ff == RATE_RST);

   // ======================================================================
   // rate counter: loads are done by the sequencer below
   logic cnt_load;
   logic cnt_stop;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rate_cnt_ff <= RATE_RST;
         cnt_run_ff <= 1'b0;
      end else if (cnt_load) begin
         rate_cnt_ff <= RATE_RELOAD_VALUE;
         cnt_run_ff <= 1'b1;
      end else if (cnt_stop) begin
         cnt_run_ff <= 1'b0;
      end else if (cnt_run_ff && rate_cnt_ff != RATE_RST) begin
         rate_cnt_ff <= rate_cnt_ff - 8'h01;
      end
   end

   // ======================================================================
   // sequencer
   logic tx_start;

   // a buffer write starts a transmit only from idle
   assign tx_start = BUF_WR && idle && !RESTART_REQUEST && !RECEIVE_REQUEST
                     && !ACK_SEND_REQUEST;

   // load/stop decisions mirror the state transitions below, except that a receive ends with a reload, not a stop
   always_comb begin
      cnt_load = 1'b0;
      cnt_stop = 1'b0;
      case (state_ff)
         I2CMS_IDLE: begin
            if (tx_start || (RECEIVE_REQUEST && !RESTART_REQUEST) ||
                (ACK_SEND_REQUEST && !RESTART_REQUEST && !RECEIVE_REQUEST)) begin
               cnt_load = 1'b1;
            end
         end
         I2CMS_RS_LOW: cnt_load = !scl_s && !cnt_run_ff;
         I2CMS_RS_SDAHI: cnt_stop = timeout;
         I2CMS_RS_WAITHI: cnt_load = scl_s;
         I2CMS_RS_BOTHHI: cnt_load = timeout;
         I2CMS_RS_SDALO: cnt_stop = timeout; // no reload
         I2CMS_TX_LOW, I2CMS_RX_LOW, I2CMS_ACK_LOW: begin
            cnt_stop = timeout; // pause until SCL seen high
         end
         I2CMS_TX_HIGH, I2CMS_RX_HIGH, I2CMS_ACK_HIGH: begin
            if (!cnt_run_ff && scl_s) begin
               cnt_load = 1'b1;
            end else if (timeout) begin
               cnt_load = !((state_ff == I2CMS_TX_HIGH && bit_cnt_ff == ACK_BIT_NUM) ||
                            (state_ff == I2CMS_RX_HIGH && bit_cnt_ff == BITS_PER_BYTE) ||
                            state_ff == I2CMS_ACK_HIGH);
               cnt_stop = !cnt_load;
            end
         end
         default: cnt_stop = 1'b1;
      endcase
   end

   // phase machine, bit counter and line drivers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_ff <= I2CMS_IDLE;
         bit_cnt_ff <= CNT_RST;
         shift_ff <= BYTE_RST;
         sda_drv_low_ff <= 1'b0;
         scl_drv_low_ff <= 1'b0;
      end else if (bcol_set) begin
         state_ff <= I2CMS_IDLE; // abort and release both lines
         sda_drv_low_ff <= 1'b0;
         scl_drv_low_ff <= 1'b0;
      end else begin
         case (state_ff)
            I2CMS_IDLE: begin
               if (RESTART_REQUEST) begin
                  state_ff <= I2CMS_RS_LOW;
                  scl_drv_low_ff <= 1'b1;
               end else if (RECEIVE_REQUEST) begin
                  state_ff <= I2CMS_RX_LOW;
                  sda_drv_low_ff <= 1'b0;
                  scl_drv_low_ff <= 1'b1;
                  bit_cnt_ff <= CNT_RST;
               end else if (ACK_SEND_REQUEST) begin
                  state_ff <= I2CMS_ACK_LOW;
                  scl_drv_low_ff <= 1'b1;
                  sda_drv_low_ff <= !ACK_VALUE_BIT;
               end else if (tx_start) begin
                  state_ff <= I2CMS_TX_LOW; // msb first
                  scl_drv_low_ff <= 1'b1;
                  shift_ff <= {BUF_WDATA[DATA_W-2:0], 1'b1};
                  sda_drv_low_ff <= !BUF_WDATA[DATA_W-1];
                  bit_cnt_ff <= 4'h1;
               end
            end
            I2CMS_RS_LOW: begin
               if (!scl_s && !cnt_run_ff) begin
                  sda_drv_low_ff <= 1'b0; // release SDA
               end else if (timeout && sda_s) begin
                  state_ff <= I2CMS_RS_SDAHI;
               end
            end
            I2CMS_RS_SDAHI: begin
               scl_drv_low_ff <= 1'b0;
               state_ff <= I2CMS_RS_WAITHI;
            end
            I2CMS_RS_WAITHI: if (scl_s) state_ff <= I2CMS_RS_BOTHHI;
            I2CMS_RS_BOTHHI: begin
               if (timeout) begin
                  sda_drv_low_ff <= 1'b1;
                  state_ff <= I2CMS_RS_SDALO;
               end
            end
            I2CMS_RS_SDALO: begin
               if (timeout) begin
                  scl_drv_low_ff <= 1'b1; // SDA left low
                  state_ff <= I2CMS_IDLE;
               end
            end
            I2CMS_TX_LOW, I2CMS_RX_LOW, I2CMS_ACK_LOW: begin
               if (timeout) begin
                  scl_drv_low_ff <= 1'b0;
                  state_ff <= (state_ff == I2CMS_TX_LOW) ? I2CMS_TX_HIGH :
                              (state_ff == I2CMS_RX_LOW) ? I2CMS_RX_HIGH : I2CMS_ACK_HIGH;
               end
            end
            I2CMS_TX_HIGH: begin
               if (cnt_run_ff && timeout) begin
                  scl_drv_low_ff <= 1'b1;
                  if (bit_cnt_ff == ACK_BIT_NUM) begin
                     state_ff <= I2CMS_IDLE; // SDA untouched
                  end else begin
                     state_ff <= I2CMS_TX_LOW;
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     // after the eighth fall SDA is released
                     sda_drv_low_ff <= (bit_cnt_ff == BITS_PER_BYTE) ? 1'b0 : !shift_ff[DATA_W-1];
                     shift_ff <= {shift_ff[DATA_W-2:0], 1'b1};
                  end
               end
            end
            I2CMS_RX_HIGH: begin
               if (cnt_run_ff && timeout) begin
                  scl_drv_low_ff <= 1'b1;
                  shift_ff <= {shift_ff[DATA_W-2:0], sda_s};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  state_ff <= (bit_cnt_ff == BITS_PER_BYTE - 4'h1) ? I2CMS_IDLE : I2CMS_RX_LOW;
               end
            end
            I2CMS_ACK_HIGH: begin
               if (cnt_run_ff && timeout) begin
                  scl_drv_low_ff <= 1'b1;
                  sda_drv_low_ff <= 1'b0;
                  state_ff <= I2CMS_IDLE;
               end
            end
            default: state_ff <= I2CMS_IDLE;
         endcase
      end
   end

   // ======================================================================
   // request bits self-clear when their sequence completes
   logic rx_done;
   assign rx_done = state_ff == I2CMS_RX_HIGH && cnt_run_ff && timeout &&
                    bit_cnt_ff == BITS_PER_BYTE - 4'h1;

   always_ff @(posedge REF_CLK) begin
      if (RST || bcol_set) begin
         rs_req_ff <= 1'b0;
         rx_req_ff <= 1'b0;
         ack_req_ff <= 1'b0;
      end else begin
         if (idle && RESTART_REQUEST) rs_req_ff <= 1'b1;
         else if (state_ff == I2CMS_RS_SDALO && timeout) rs_req_ff <= 1'b0;
         if (idle && RECEIVE_REQUEST && !RESTART_REQUEST) rx_req_ff <= 1'b1;
         else if (rx_done) rx_req_ff <= 1'b0;
         if (idle && ACK_SEND_REQUEST && !RESTART_REQUEST && !RECEIVE_REQUEST)
            ack_req_ff <= 1'b1;
         else if (state_ff == I2CMS_ACK_HIGH && cnt_run_ff && timeout)
            ack_req_ff <= 1'b0;
      end
   end

   // ======================================================================
   // holding buffer and full flag; full set wins over read clear
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         hold_ff <= BYTE_RST;
         full_ff <= 1'b0;
      end else if (tx_start) begin
         hold_ff <= BUF_WDATA;
         full_ff <= 1'b1;
      end else if (rx_done) begin
         hold_ff <= {shift_ff[DATA_W-2:0], sda_s};
         full_ff <= 1'b1;
      end else if (state_ff == I2CMS_TX_HIGH && timeout && bit_cnt_ff == BITS_PER_BYTE) begin
         full_ff <= 1'b0;
      end else if (BUF_RD) begin
         full_ff <= 1'b0;
      end
   end

   // ======================================================================
   // status flags
   // a buffer write while busy is refused and flagged
   logic write_collision_flag_set;
   assign write_collision_flag_set = BUF_WR && !tx_start;
   assign ovr_set = rx_done && full_ff;
   // restart collisions: SDA low at SCL rise, SCL falls before SDA driven
   assign bcol_set = (state_ff == I2CMS_RS_WAITHI && scl_s && !scl_prev_ff && !sda_s) ||
                     (state_ff == I2CMS_RS_BOTHHI && !scl_s && scl_prev_ff);
   assign irq_set = (state_ff == I2CMS_RS_SDALO && timeout) ||
                    (state_ff == I2CMS_TX_HIGH && cnt_run_ff && timeout &&
                     bit_cnt_ff == ACK_BIT_NUM) || rx_done ||
                    (state_ff == I2CMS_ACK_HIGH && cnt_run_ff && timeout);

   // sticky flags; hardware set beats software clear
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         write_collision_flag_ff <= 1'b0;
         ovr_ff <= 1'b0;
         irq_ff <= 1'b0;
         bcol_ff <= 1'b0;
      end else begin
         write_collision_flag_ff <= write_collision_flag_set | (write_collision_flag_ff & ~WRITE_COLLISION_FLAG_CLR);
         ovr_ff <= ovr_set | (ovr_ff & ~OVR_CLR);
         irq_ff <= irq_set | (irq_ff & ~IRQ_CLR);
         bcol_ff <= bcol_set | (bcol_ff & ~BCOL_CLR);
      end
   end

   // acknowledge capture on ninth rising edge; start pattern detection
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ack_received_status_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         if (state_ff == I2CMS_TX_HIGH && bit_cnt_ff == ACK_BIT_NUM && !cnt_run_ff && scl_s)
            ack_received_status_ff <= sda_s;
         if (scl_s && sda_prev_ff && !sda_s)
            start_ff <= 1'b1;
         else if (scl_s && !sda_prev_ff && sda_s)
            start_ff <= 1'b0; // stop pattern ends it
      end
   end

   // ======================================================================
   // outputs: open-drain, only ever pull low
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         SCL_OUT <= 1'b0;
         SCL_OE <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
         SDA_OE <= sda_drv_low_ff;
         SCL_OUT <= 1'b0;
         SCL_OE <= scl_drv_low_ff;
      end
   end

   // status outputs registered once more
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         HOLDING_BUFFER <= BYTE_RST;
         HOLDING_FULL_FLAG <= 1'b0;
         WRITE_COLLISION_FLAG <= 1'b0;
         RECEIVE_OVERRUN_FLAG <= 1'b0;
         ACK_RECEIVED_STATUS <= 1'b0;
         PORT_IRQ_FLAG <= 1'b0;
         START_SEEN <= 1'b0;
         BUS_COLLISION <= 1'b0;
         RESTART_BUSY <= 1'b0;
         RECEIVE_BUSY <= 1'b0;
         ACK_SEND_BUSY <= 1'b0;
      end else begin
         HOLDING_BUFFER <= hold_ff;
         HOLDING_FULL_FLAG <= full_ff;
         WRITE_COLLISION_FLAG <= write_collision_flag_ff;
         RECEIVE_OVERRUN_FLAG <= ovr_ff;
         ACK_RECEIVED_STATUS <= ack_received_status_ff;
         PORT_IRQ_FLAG <= irq_ff;
         START_SEEN <= start_ff;
         BUS_COLLISION <= bcol_ff;
         RESTART_BUSY <= rs_req_ff;
         RECEIVE_BUSY <= rx_req_ff;
         ACK_SEND_BUSY <= ack_req_ff;
      end
   end
endmodule
`default_nettype wire

// ### testbench/i2cms_slave_model.sv
// Purpose: two-wire slave stand-in for the sequencer bench
// Assumes: open-drain lines with pull-ups; bench arms it before each byte
// Notes: counts clock rises; optional stretch of every low phase
`timescale 1ns/1ps
`default_nettype none
module i2cms_slave_model (
   input wire logic scl,
   input wire logic arm,
   input wire logic rx_mode,
   input wire logic ack_en,
   input wire logic stretch_en,
   input wire logic [7:0] tx_byte,
   output logic sda_low,
   output logic scl_low
);
   int cnt;
   // ======================================================================
   // line control
   // released lines float to the pull-up level
   initial begin
      cnt = 0;
      sda_low = 1'b0;
      scl_low = 1'b0;
   end
   // a new byte starts at bit seven
   always @(posedge arm) begin
      cnt = 0;
      sda_low = rx_mode & ~tx_byte[7];
   end
   // one count per clock rise
   always @(posedge scl) cnt = cnt + 1;
   // data only moves while the clock is low
   always @(negedge scl) begin
      if (rx_mode) begin
         sda_low = (cnt < 8) ? ~tx_byte[7 - cnt] : 1'b0;
      end else begin
         sda_low = (cnt == 8) & ack_en; // ninth-bit answer
      end
      if (stretch_en) begin
         scl_low = 1'b1;
         #300 scl_low = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### testbench/i2cms_sequencer_props.sv
// Purpose: port-level timing checks for the master sequencer
// Assumes: reload of 3, so one rate period is at least four clocks
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module i2cms_sequencer_props (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic BUF_WR,
   input wire logic RESTART_REQUEST,
   input wire logic RECEIVE_REQUEST,
   input wire logic ACK_SEND_REQUEST,
   input wire logic ACK_VALUE_BIT,
   input wire logic SCL_IN,
   input wire logic SDA_OE,
   input wire logic SCL_OE,
   input wire logic [i2cms_pkg::DATA_W-1:0] HOLDING_BUFFER,
   input wire logic HOLDING_FULL_FLAG,
   input wire logic WRITE_COLLISION_FLAG,
   input wire logic PORT_IRQ_FLAG,
   input wire logic START_SEEN,
   input wire logic BUS_COLLISION,
   input wire logic RESTART_BUSY,
   input wire logic RECEIVE_BUSY,
   input wire logic ACK_SEND_BUSY
);
   import i2cms_pkg::*;
   logic any_req;
   // ======================================================================
   // helpers
   assign any_req = BUF_WR | RESTART_REQUEST | RECEIVE_REQUEST | ACK_SEND_REQUEST;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence s_calm;
      !any_req [*3];
   endsequence
   sequence s_ack_req;
      ACK_SEND_REQUEST && !RECEIVE_BUSY && !RESTART_BUSY && !ACK_SEND_BUSY;
   endsequence
   // ======================================================================
   // checks
   a_write_flags: assert property (BUF_WR |-> ##2 (HOLDING_FULL_FLAG || WRITE_COLLISION_FLAG))
      else $error("buffer write left no flag");
   a_col_buf_kept: assert property ($rose(WRITE_COLLISION_FLAG) |->
      HOLDING_BUFFER == $past(HOLDING_BUFFER, 2))
      else $error("refused write changed the buffer");
   a_rx_write_refused: assert property (BUF_WR && RECEIVE_BUSY ##2 RECEIVE_BUSY |-> WRITE_COLLISION_FLAG)
      else $error("write during receive not flagged");
   a_restart_dropped: assert property (RESTART_REQUEST && RECEIVE_BUSY ##2 RECEIVE_BUSY |-> !RESTART_BUSY)
      else $error("restart taken while busy");
   a_rx_dropped: assert property (RECEIVE_REQUEST && ACK_SEND_BUSY ##2 ACK_SEND_BUSY |-> !RECEIVE_BUSY)
      else $error("receive taken while busy");
   a_irq_scl_low: assert property ($rose(PORT_IRQ_FLAG) && !BUS_COLLISION |-> SCL_OE)
      else $error("interrupt with clock released");
   a_scl_parked: assert property (s_calm ##0 (PORT_IRQ_FLAG && SCL_OE && !BUS_COLLISION) |=> SCL_OE)
      else $error("clock released without request");
   a_ack_drive: assert property (s_ack_req |-> ##2 (SCL_OE && SDA_OE == !$past(ACK_VALUE_BIT, 2)))
      else $error("acknowledge value not driven");
   a_ack_span: assert property ($rose(ACK_SEND_BUSY) |-> ACK_SEND_BUSY [*8])
      else $error("acknowledge shorter than two periods");
   a_restart_done: assert property ($fell(RESTART_BUSY) && !BUS_COLLISION |->
      SCL_OE && SDA_OE && START_SEEN)
      else $error("restart ended in wrong line state");
   a_irq_after_start: assert property ($rose(START_SEEN) && !PORT_IRQ_FLAG |=> !PORT_IRQ_FLAG)
      else $error("interrupt together with start");
   a_sda_steady: assert property (SCL_IN && $past(SCL_IN) && !RESTART_BUSY && !$past(RESTART_BUSY)
      && !BUS_COLLISION |-> $stable(SDA_OE))
      else $error("data moved while clock high");
endmodule
bind i2cms_sequencer i2cms_sequencer_props props_i (.*);
`default_nettype wire

// ### testbench/test_i2cms_sequencer.sv
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: reload 3 gives a 240 ns bit clock at 50 MHz
// Notes: a third-party pull-down on data forces the collision case
`timescale 1ns/1ps
`default_nettype none
module test_i2cms_sequencer;
   import i2cms_pkg::*;
   logic clk, rst, ackv, arm, rx_mode, ack_en, stretch, coll_low, scl_q;
   logic sda_oe, scl_oe, sda_low, scl_low, sda, scl, full, write_collision_flag, ovr, ackst;
   logic irq, sseen, bcol, rs_busy, rx_busy, ak_busy, sda_o, scl_o;
   logic [4:0] req; // read, ack, receive, restart, write
   logic [3:0] clr; // bus col, overrun, write col, irq
   logic [7:0] wdata, sbyte, hbuf;
   logic [8:0] wire_sr;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int run = 0;
   int hi_min = 99;
   // open-drain wires with pull-ups
   assign sda = ~(sda_oe | sda_low | coll_low);
   assign scl = ~(scl_oe | scl_low);
   // ======================================================================
   // design and partner
   i2cms_sequencer DUT (.REF_CLK(clk), .RST(rst), .RATE_RELOAD_VALUE(8'h03),
      .BUF_WDATA(wdata), .BUF_WR(req[0]), .BUF_RD(req[4]), .RESTART_REQUEST(req[1]),
      .RECEIVE_REQUEST(req[2]), .ACK_SEND_REQUEST(req[3]), .ACK_VALUE_BIT(ackv),
      .IRQ_CLR(clr[0]), .WRITE_COLLISION_FLAG_CLR(clr[1]), .OVR_CLR(clr[2]), .BCOL_CLR(clr[3]),
      .SDA_IN(sda), .SCL_IN(scl), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
      .SCL_OUT(scl_o), .SCL_OE(scl_oe),
      .HOLDING_BUFFER(hbuf), .HOLDING_FULL_FLAG(full), .WRITE_COLLISION_FLAG(write_collision_flag),
      .RECEIVE_OVERRUN_FLAG(ovr), .ACK_RECEIVED_STATUS(ackst), .PORT_IRQ_FLAG(irq),
      .START_SEEN(sseen), .BUS_COLLISION(bcol), .RESTART_BUSY(rs_busy),
      .RECEIVE_BUSY(rx_busy), .ACK_SEND_BUSY(ak_busy));
   i2cms_slave_model slave_i (.scl(scl), .arm(arm), .rx_mode(rx_mode), .ack_en(ack_en),
      .stretch_en(stretch), .tx_byte(sbyte), .sda_low(sda_low), .scl_low(scl_low));
   // ======================================================================
   // clock, monitors, watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // bits seen on the wire, shortest clock-high phase
   always @(posedge scl) wire_sr <= {wire_sr[7:0], sda};
   always @(posedge clk) begin
      scl_q <= scl;
      run <= (scl == scl_q) ? run + 1 : 1;
      if (scl != scl_q && scl_q && !rst && run < hi_min) hi_min <= run;
   end
   // a hang ends the run instead of stalling it
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("unexpected timeout at cycle %0d", cyc);
         end_of_test();
      end
   end
   // ======================================================================
   // tasks
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // one-cycle strobes, then time for the flags to land
   task automatic hit(input logic [4:0] r, input logic [3:0] c, input logic [7:0] d,
      input logic a);
      @(posedge clk);
      req <= r;
      clr <= c;
      wdata <= d;
      ackv <= a;
      @(posedge clk);
      req <= 5'h00;
      clr <= 4'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   function automatic logic cond(input int sel);
      case (sel)
         0: return irq === 1'b1;
         1: return scl_oe === 1'b0;
         default: return bcol === 1'b1;
      endcase
   endfunction
   task automatic wait_on(input int sel);
      int n;
      n = 0;
      // look on the falling edge so the registered outputs have settled
      while (!cond(sel) && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk("wait bound", 12'(n == 2000), 12'h000);
   endtask
   task automatic slave(input logic rx, input logic [7:0] b, input logic a);
      @(posedge clk);
      rx_mode <= rx;
      sbyte <= b;
      ack_en <= a;
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
   endtask
   task automatic send(input logic [7:0] b, input logic a, input logic clash);
      slave(1'b0, b, a);
      hit(5'h00, 4'h1, b, 1'b0); // clear irq first
      hit(5'h01, 4'h0, b, 1'b0);
      chk("full on write", 12'(full), 12'h001);
      if (clash) begin
         hit(5'h01, 4'h0, ~b, 1'b0);
         chk("tx clash", 12'({write_collision_flag, hbuf}), 12'({1'b1, b}));
      end
      wait_on(0);
      chk("wire bits", 12'(wire_sr), 12'({b, ~a}));
      chk("after byte", 12'({full, ackst}), 12'({1'b0, ~a}));
      hit(5'h00, 4'h2, b, 1'b0); // clear collision before next byte
   endtask
   task automatic recv(input logic [7:0] b, input logic pokes);
      slave(1'b1, b, 1'b0);
      hit(5'h00, 4'h1, 8'h00, 1'b0);
      hit(5'h04, 4'h0, 8'h00, 1'b0);
      if (pokes) begin
         hit(5'h02, 4'h0, 8'h00, 1'b0);
         chk("restart dropped", 12'(rs_busy), 12'h000);
         hit(5'h01, 4'h0, 8'hFF, 1'b0);
         chk("rx clash", 12'({write_collision_flag, hbuf == 8'hFF}), 12'h002);
      end
      wait_on(0);
      chk("rx byte", 12'({full, irq, rx_busy, hbuf}), 12'({3'b110, b}));
   endtask
   task automatic ack_seq(input logic v);
      hit(5'h00, 4'h1, 8'h00, v);
      hit(5'h08, 4'h0, 8'h00, v);
      hit(5'h04, 4'h0, 8'h00, v);
      wait_on(0);
      chk("ack sent", 12'({wire_sr[0], ak_busy, rx_busy, scl}), 12'({v, 3'b000}));
   endtask
   task automatic end_of_test();
      $display("compares %0d, n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ======================================================================
   // main sequence
   initial begin
      {rst, req, clr, wdata, ackv, arm, rx_mode, ack_en} = {1'b1, 21'h0};
      {stretch, coll_low, sbyte, wire_sr} = 19'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("idle", 12'({sda_oe, scl_oe, irq, full, bcol, sda_o, scl_o}), 12'h000);
      hit(5'h02, 4'h0, 8'h00, 1'b0);
      wait_on(0);
      chk("restart", 12'({sseen, rs_busy, sda, scl, bcol}), 12'h010);
      send(8'hA5, 1'b1, 1'b0);
      send(8'h3C, 1'b0, 1'b1);
      stretch = 1'b1;
      send(8'h5A, 1'b1, 1'b0);
      stretch = 1'b0;
      chk("high phase", 12'(hi_min >= 4), 12'h001);
      recv(8'h96, 1'b1);
      chk("no overrun", 12'(ovr), 12'h000);
      recv(8'h69, 1'b0);
      chk("overrun", 12'(ovr), 12'h001);
      hit(5'h10, 4'h6, 8'h00, 1'b0);
      chk("read clears", 12'({full, ovr, write_collision_flag}), 12'h000);
      ack_seq(1'b0);
      ack_seq(1'b1);
      hit(5'h00, 4'h1, 8'h00, 1'b0);
      hit(5'h02, 4'h0, 8'h00, 1'b0);
      wait_on(1);
      coll_low = 1'b1;
      wait_on(2);
      coll_low = 1'b0;
      chk("collision", 12'(bcol), 12'h001);
      hit(5'h00, 4'h8, 8'h00, 1'b0);
      chk("collision cleared", 12'(bcol), 12'h000);
      end_of_test();
   end
endmodule
`default_nettype wire
